// File: hdl/owts_top.v
/*
 Open-wire and thermal fault sequencer: rail and sense line open-wire
 response, periodic odd/even tap probing with qualification, arbitration
 against overcharge/overdischarge delay timers, thermistor protection,
 APB registers and a level interrupt.
 Assumes comparator inputs synchronous to clk and an APB master.
*/
// Chosen here: the APB slave port and the placing of the registers.
// Functional notes
// - Open top or bottom line floats charge drive, pulls discharge low.
// - Broken separate sense line pulls only discharge low.
// - Open supply or ground line floats charge drive, pulls discharge low.
// - Tap probing cycle starts every 1.25 s from internal timing.
// - Successive probes alternate odd-tap group and even-tap group.
// - Selected tap group stays switched on for about 140 ms.
// - No tap shift during the window ends the cycle quietly.
// - Tap shift held 0.5 ms declares fault, floats charge, discharge low.
// - Mode select disable code suppresses tap probing.
// - Standby stops tap probing, keeps rail open-wire detection.
// - Running overcharge delay holds off the next probing cycle.
// - No overcharge delay start during probing; start afterward if still high.
// - Overdischarge delay and probing exclude each other.
// - Overdischarge delay is lengthened by any probing while pending.
// - Thermistor above threshold for detect delay trips both drives.
// - Below release threshold for release delay restores both drives.
// - Standby pulls thermistor supply low and stops temperature checks.
// - Both mode selects low gives five-cell mode without tap probing; rail and sense open-wire detection stay active.
`include "owts_regs.vh"
module owts_top #(
   parameter CLK_HZ     = `OWTS_CLK_HZ,
   parameter TICK_HZ    = `OWTS_TICK_HZ,
   parameter PERIOD_MS  = `OWTS_PERIOD_MS,
   parameter WINDOW_MS  = `OWTS_WINDOW_MS,
   parameter QUAL_US    = `OWTS_QUAL_US
)(
   // Clock and reset
   input  wire        clk,
   input  wire        resetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Mode and comparator inputs
   input  wire        mode_select_a,
   input  wire        mode_select_b,
   input  wire        rail_open,
   input  wire        sense_open,
   input  wire        tap_shift,
   input  wire        thermistor_sense,
   input  wire        thermistor_release,
   input  wire        over_charge_cmp,
   input  wire        over_discharge_cmp,
   // Arbitration with the voltage delay timers
   input  wire        oc_delay_done,
   input  wire        od_delay_done,
   output reg         oc_delay_run,
   output reg         od_delay_run,
   // Switch groups, FET drives and thermistor supply
   output reg         odd_group_switch,
   output reg         even_group_switch,
   output reg         charge_fet_drive,
   output reg         charge_fet_drive_oe,
   output reg         discharge_fet_drive,
   output reg         thermistor_supply,
   output reg         irq
);
   // Cycle counts derived from the timing figures
   localparam integer TICK_DIV  = CLK_HZ / TICK_HZ;
   localparam integer QUAL_CYC  = (CLK_HZ / 1000) * QUAL_US / 1000;
   localparam integer PERIOD_TK = PERIOD_MS * TICK_HZ / 1000;
   localparam integer WINDOW_TK = WINDOW_MS * TICK_HZ / 1000;
   localparam [1:0] PS_IDLE = 2'h0;
   localparam [1:0] PS_PROBE = 2'h1;

   // Register address decode
   function sel_match;
      input [11:0] a;
      input [11:0] ofs;
      begin
         sel_match = (a == ofs);
      end
   endfunction

   reg [31:0] div_r;
   reg        tick_r;
   reg [15:0] per_r;
   reg [15:0] win_r;
   reg [1:0]  ps_r;
   reg        odd_r;
   reg [31:0] qual_r;
   reg        tap_flt_r;
   reg        temp_flt_r;
   reg [`OWTS_CTRL_W-1:0] ctrl_r;
   reg [`OWTS_EV_W-1:0]   irq_st_r;
   reg [`OWTS_EV_W-1:0]   mask_r;
   reg [15:0] tdet_r;
   reg [15:0] trel_r;
   reg        rail_d_r;
   reg        sense_d_r;
   reg        temp_d_r;

   wire standby  = ctrl_r[`OWTS_CTRL_STANDBY];
   wire probing  = (ps_r == PS_PROBE);
   wire sel_off  = ({mode_select_a, mode_select_b} == `OWTS_SEL_NOWIRE);
   wire tap_ok   = ctrl_r[`OWTS_CTRL_TAPEN] && !sel_off && !standby;
   wire qual_hit = (qual_r + 1 >= QUAL_CYC);
   // Start of a probe cycle
   wire probe_go = (ps_r == PS_IDLE) && tick_r && (per_r >= PERIOD_TK - 1) && tap_ok
                   && !tap_flt_r && !oc_delay_run && !od_delay_run;
   wire det_met;
   wire rel_met;
   wire wr       = psel && penable && pwrite;
   wire [`OWTS_EV_W-1:0] ev;
   wire [`OWTS_ST_W-1:0] st;

   // Temperature qualifiers
   owts_qual #(.W(16)) u_det (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick_r),
      .cond   (thermistor_sense && !standby && !temp_flt_r),
      .limit  (tdet_r),
      .met_r  (det_met)
   );
   owts_qual #(.W(16)) u_rel (
      .clk    (clk),
      .resetn (resetn),
      .tick   (tick_r),
      .cond   (!thermistor_release && !standby && temp_flt_r),
      .limit  (trel_r),
      .met_r  (rel_met)
   );

   // Slow tick
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_r  <= 32'h0000_0000;
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= (div_r == TICK_DIV - 1);
         div_r  <= (div_r == TICK_DIV - 1) ? 32'h0000_0000 : div_r + 1'b1;
      end
   end

   // Probe sequencer
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         per_r     <= 16'h0000;
         win_r     <= 16'h0000;
         ps_r      <= PS_IDLE;
         odd_r     <= 1'b1;
         qual_r    <= 32'h0000_0000;
         tap_flt_r <= 1'b0;
      end
      else
      begin
         if (tick_r)
            per_r <= (per_r >= PERIOD_TK - 1) ? 16'h0000 : per_r + 1'b1;
         case (ps_r)
            PS_IDLE:
            begin
               qual_r <= 32'h0000_0000;
               if (probe_go)
               begin
                  ps_r  <= PS_PROBE;
                  win_r <= 16'h0000;
               end
            end
            PS_PROBE:
            begin
               if (!tap_ok)
                  ps_r <= PS_IDLE;
               else if (tap_shift)
               begin
                  qual_r <= qual_r + 1;
                  if (qual_hit)
                  begin
                     // Tap fault stays set until reset
                     tap_flt_r <= 1'b1;
                     ps_r      <= PS_IDLE;
                  end
               end
               else
                  qual_r <= 32'h0000_0000;
               if (tick_r)
               begin
                  win_r <= win_r + 1'b1;
                  if (win_r >= WINDOW_TK - 1)
                  begin
                     ps_r  <= PS_IDLE;
                     odd_r <= !odd_r;
                  end
               end
            end
            default:
               ps_r <= PS_IDLE;
         endcase
      end
   end

   // Delay timer arbitration; no start while probing or on the probe start edge
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         oc_delay_run <= 1'b0;
         od_delay_run <= 1'b0;
      end
      else
      begin
         if (oc_delay_done || !over_charge_cmp)
            oc_delay_run <= 1'b0;
         else if (!probing && !probe_go)
            oc_delay_run <= 1'b1;
         if (od_delay_done || !over_discharge_cmp)
            od_delay_run <= 1'b0;
         else if (!probing && !probe_go)
            od_delay_run <= 1'b1;
      end
   end

   // Temperature fault flag
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         temp_flt_r <= 1'b0;
      else if (det_met)
         temp_flt_r <= 1'b1;
      else if (rel_met)
         temp_flt_r <= 1'b0;
   end

   // Switch groups, FET drives and thermistor supply
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         odd_group_switch    <= 1'b0;
         even_group_switch   <= 1'b0;
         charge_fet_drive    <= 1'b1;
         charge_fet_drive_oe <= 1'b1;
         discharge_fet_drive <= 1'b1;
         thermistor_supply   <= 1'b0;
      end
      else
      begin
         odd_group_switch  <= probing && odd_r;
         even_group_switch <= probing && !odd_r;
         thermistor_supply <= !standby;
         charge_fet_drive    <= 1'b1;
         charge_fet_drive_oe <= !(rail_open || tap_flt_r || temp_flt_r);
         discharge_fet_drive <= !(rail_open || sense_open || tap_flt_r
                                  || temp_flt_r);
      end
   end

   // Events and status
   assign ev[`OWTS_EV_RAIL]  = rail_open && !rail_d_r;
   assign ev[`OWTS_EV_SENSE] = sense_open && !sense_d_r;
   assign ev[`OWTS_EV_TAP]   = probing && tap_shift && qual_hit;
   assign ev[`OWTS_EV_TEMP]  = temp_flt_r && !temp_d_r;
   assign ev[`OWTS_EV_TREL]  = !temp_flt_r && temp_d_r;
   assign st = {od_delay_run, oc_delay_run, odd_r, probing,
                temp_flt_r, tap_flt_r, sense_open, rail_open};

   // APB register file
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r    <= `OWTS_CTRL_RST;
         irq_st_r  <= {`OWTS_EV_W{1'b0}};
         mask_r    <= {`OWTS_EV_W{1'b0}};
         tdet_r    <= `OWTS_TDET_RST;
         trel_r    <= `OWTS_TREL_RST;
         rail_d_r  <= 1'b0;
         sense_d_r <= 1'b0;
         temp_d_r  <= 1'b0;
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         irq       <= 1'b0;
      end
      else
      begin
         rail_d_r  <= rail_open;
         sense_d_r <= sense_open;
         temp_d_r  <= temp_flt_r;
         pready    <= psel && !penable;
         pslverr   <= 1'b0;
         if (wr && pready && sel_match(paddr, `OWTS_IRQ_OFS))
            irq_st_r <= (irq_st_r & ~pwdata[`OWTS_EV_W-1:0]) | ev;
         else
            irq_st_r <= irq_st_r | ev;
         irq <= |(irq_st_r & mask_r);
         if (wr && pready)
         begin
            if (sel_match(paddr, `OWTS_CTRL_OFS))
               ctrl_r <= pwdata[`OWTS_CTRL_W-1:0];
            else if (sel_match(paddr, `OWTS_MASK_OFS))
               mask_r <= pwdata[`OWTS_EV_W-1:0];
            else if (sel_match(paddr, `OWTS_TDET_OFS))
               tdet_r <= pwdata[15:0];
            else if (sel_match(paddr, `OWTS_TREL_OFS))
               trel_r <= pwdata[15:0];
         end
         if (psel && !penable)
         begin
            pslverr <= !(sel_match(paddr, `OWTS_CTRL_OFS) || sel_match(paddr, `OWTS_STATUS_OFS)
                       || sel_match(paddr, `OWTS_IRQ_OFS) || sel_match(paddr, `OWTS_MASK_OFS)
                       || sel_match(paddr, `OWTS_TDET_OFS)
                       || sel_match(paddr, `OWTS_TREL_OFS));
            if (sel_match(paddr, `OWTS_CTRL_OFS))
               prdata <= {30'h0, ctrl_r};
            else if (sel_match(paddr, `OWTS_STATUS_OFS))
               prdata <= {24'h0, st};
            else if (sel_match(paddr, `OWTS_IRQ_OFS))
               prdata <= {27'h0, irq_st_r};
            else if (sel_match(paddr, `OWTS_MASK_OFS))
               prdata <= {27'h0, mask_r};
            else if (sel_match(paddr, `OWTS_TDET_OFS))
               prdata <= {16'h0, tdet_r};
            else if (sel_match(paddr, `OWTS_TREL_OFS))
               prdata <= {16'h0, trel_r};
            else
               prdata <= 32'h0000_0000;
         end
      end
   end
endmodule // owts_top

// File: pkg/owts_regs.vh
/*
 Constants for the open-wire and thermal fault sequencer: register offsets,
 field positions, reset values and timing figures.
 Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
`ifndef OWTS_REGS_VH
`define OWTS_REGS_VH

// Register byte offsets
`define OWTS_CTRL_OFS     12'h000
`define OWTS_STATUS_OFS   12'h004
`define OWTS_IRQ_OFS      12'h008
`define OWTS_MASK_OFS     12'h00c
`define OWTS_TDET_OFS     12'h010
`define OWTS_TREL_OFS     12'h014

// Control fields
`define OWTS_CTRL_STANDBY 0
`define OWTS_CTRL_TAPEN   1
`define OWTS_CTRL_W       2
`define OWTS_CTRL_RST     2'h2

// Status fields
`define OWTS_ST_RAIL      0
`define OWTS_ST_SENSE     1
`define OWTS_ST_TAP       2
`define OWTS_ST_TEMP      3
`define OWTS_ST_PROBE     4
`define OWTS_ST_ODD       5
`define OWTS_ST_OCDLY     6
`define OWTS_ST_ODDLY     7
`define OWTS_ST_W         8

// Interrupt event bits
`define OWTS_EV_RAIL      0
`define OWTS_EV_SENSE     1
`define OWTS_EV_TAP       2
`define OWTS_EV_TEMP      3
`define OWTS_EV_TREL      4
`define OWTS_EV_W         5

// Mode select encoding {mode_select_a, mode_select_b}; 2'b00 = probing disabled
`define OWTS_SEL_NOWIRE   2'b00

// Timing figures
`define OWTS_CLK_HZ          125000000
`define OWTS_PERIOD_MS       1250
`define OWTS_WINDOW_MS       140
`define OWTS_QUAL_US         500
`define OWTS_TDET_RST        16'h0010
`define OWTS_TREL_RST        16'h0010
`define OWTS_TICK_HZ         1000

`endif

// File: hdl/owts_qual.v
/*
 Qualification counter: output rises once the input has held high for
 the programmed number of ticks; any drop restarts the count.
 Assumes a single clock and a one-cycle tick strobe.
*/
module owts_qual #(
   parameter W = 16
)(
   // Clock and reset
   input  wire         clk,
   input  wire         resetn,
   // Control
   input  wire         tick,
   input  wire         cond,
   input  wire [W-1:0] limit,
   // Result
   output reg          met_r
);
   reg [W-1:0] cnt_r;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= {W{1'b0}};
         met_r <= 1'b0;
      end
      else if (!cond)
      begin
         cnt_r <= {W{1'b0}};
         met_r <= 1'b0;
      end
      else if (tick && !met_r)
      begin
         if (cnt_r + 1'b1 >= limit)
            met_r <= 1'b1;
         cnt_r <= cnt_r + 1'b1;
      end
   end
endmodule // owts_qual

// File: bench/owts_checker.sv
/*
 Port checker for owts_top.
 Assumes one clock and the active-low asynchronous reset.
*/
module owts_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Inputs
   input wire logic rail_open,
   input wire logic sense_open,
   input wire logic tap_shift,
   input wire logic thermistor_sense,
   input wire logic mode_select_a,
   input wire logic mode_select_b,
   input wire logic oc_delay_done,
   input wire logic od_delay_done,
   // Outputs
   input wire logic oc_delay_run,
   input wire logic od_delay_run,
   input wire logic odd_group_switch,
   input wire logic even_group_switch,
   input wire logic charge_fet_drive_oe,
   input wire logic discharge_fet_drive,
   input wire logic thermistor_supply
);
   timeunit 1ns;
   timeprecision 1ps;
   wire sw = odd_group_switch | even_group_switch;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rail_trip:
      assert property (rail_open |=> !charge_fet_drive_oe && !discharge_fet_drive)
         else $error("rail open did not trip");
   a_sense_dis:
      assert property (sense_open |=> !discharge_fet_drive) else $error("sense open");
   a_group_excl:
      assert property (!(odd_group_switch && even_group_switch)) else $error("both groups");
   a_window_min:
      assert property ($rose(sw) && !tap_shift |=> sw [*8]) else $error("window short");
   a_mode_off:
      assert property ((!mode_select_a && !mode_select_b) [*2] |=> !$rose(sw))
         else $error("probe while disabled");
   a_standby_off:
      assert property (!thermistor_supply [*2] |=> !$rose(sw)) else $error("probe in standby");
   a_oc_excl:
      assert property (sw |-> !oc_delay_run) else $error("oc run in probe");
   a_od_excl:
      assert property (sw |-> !od_delay_run) else $error("od run in probe");
   a_oc_block:
      assert property (oc_delay_run [*2] |=> !$rose(sw)) else $error("probe in oc delay");
   a_dis_cause:
      assert property ($fell(discharge_fet_drive) |-> $past(rail_open || sense_open
         || tap_shift || thermistor_sense || od_delay_done)) else $error("dis fell");
   a_oe_cause:
      assert property ($fell(charge_fet_drive_oe) |-> $past(rail_open || tap_shift
         || thermistor_sense || oc_delay_done)) else $error("oe fell");
   c_probe: cover property ($rose(sw));
   c_trip: cover property ($fell(charge_fet_drive_oe));
   c_oc: cover property ($rose(oc_delay_run));
endmodule // owts_checker

bind owts_top owts_checker owts_checker_i (.clk, .resetn, .rail_open, .sense_open,
   .tap_shift, .thermistor_sense, .mode_select_a, .mode_select_b, .oc_delay_done,
   .od_delay_done, .oc_delay_run, .od_delay_run, .odd_group_switch, .even_group_switch,
   .charge_fet_drive_oe, .discharge_fet_drive, .thermistor_supply);

// File: bench/owts_cells.sv
/*
 Cells and delay timers beside the sequencer.
 Assumes switch and run levels from owts_top.
*/
module owts_cells #(parameter int DLY = 300) (
   // Clock and faults
   input  wire logic clk,
   input  wire logic tap_broken,
   input  wire logic tap_glitch,
   // From the sequencer
   input  wire logic odd_group_switch,
   input  wire logic even_group_switch,
   input  wire logic oc_delay_run,
   input  wire logic od_delay_run,
   // Comparators
   output      logic tap_shift,
   output      logic oc_delay_done,
   output      logic od_delay_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int oc_n = 0;
   int od_n = 0;
   // Tap shifts only while a group is switched on
   assign tap_shift = (tap_broken | tap_glitch) & (odd_group_switch | even_group_switch);
   // Delays count only while run, so probing stretches them
   always @(posedge clk)
   begin
      oc_n <= oc_delay_run ? oc_n + 1 : 0;
      od_n <= od_delay_run ? od_n + 1 : 0;
   end
   assign oc_delay_done = oc_n >= DLY;
   assign od_delay_done = od_n >= DLY;
endmodule // owts_cells

// File: bench/testbench.sv
/*
 Self-checking bench for owts_top with the cell model.
 Assumes the slow tick is every 8 clocks (CLK_HZ 8000, TICK_HZ 1000).
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 8;
   localparam int PER = 1250 * TK;
   localparam int WIN = 140 * TK;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic mode_select_a, mode_select_b, rail_open, sense_open, tap_shift;
   logic thermistor_sense, thermistor_release, over_charge_cmp, over_discharge_cmp;
   logic oc_delay_done, od_delay_done, oc_delay_run, od_delay_run, tap_broken, tap_glitch;
   logic odd_group_switch, even_group_switch, charge_fet_drive, charge_fet_drive_oe;
   logic discharge_fet_drive, thermistor_supply;
   logic [4:0] mon;
   int n, errors, n_checks;
   assign mon = {od_delay_run, oc_delay_run, discharge_fet_drive, charge_fet_drive_oe,
                 odd_group_switch | even_group_switch};
   owts_top #(.CLK_HZ(8000), .TICK_HZ(1000)) owts_top_i (.clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_select_a, .mode_select_b,
      .rail_open, .sense_open, .tap_shift, .thermistor_sense, .thermistor_release,
      .over_charge_cmp, .over_discharge_cmp, .oc_delay_done, .od_delay_done, .oc_delay_run,
      .od_delay_run, .odd_group_switch, .even_group_switch, .charge_fet_drive,
      .charge_fet_drive_oe, .discharge_fet_drive, .thermistor_supply, .irq);
   owts_cells owts_cells_i (.clk, .tap_broken, .tap_glitch, .odd_group_switch,
      .even_group_switch, .oc_delay_run, .od_delay_run, .tap_shift, .oc_delay_done,
      .od_delay_done);
   initial
   begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wt(input int i, input logic v, input int lim);
      n = 0;
      while (mon[i] !== v && n < lim)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= lim)
      begin
         errors++;
         tally_and_finish();
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 20)
      begin
         errors++;
         tally_and_finish();
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task rst(input logic [1:0] m);
      @(posedge clk);
      resetn <= 0;
      {mode_select_a, mode_select_b} <= m;
      {rail_open, sense_open, thermistor_sense, thermistor_release, over_charge_cmp} <= 5'h0;
      {over_discharge_cmp, tap_broken, tap_glitch} <= 3'h0;
      repeat (16) @(posedge clk);
      resetn <= 1;
   endtask
   task t_regs_rail;
      apb(0, 12'h000, 0);
      chk("ctrl", 2, rd);
      apb(0, 12'h010, 0);
      chk("tdet", 16, rd);
      apb(0, 12'h018, 0);
      chk("slverr", 1, se);
      @(posedge clk) rail_open <= 1;
      cyc(3);
      chk("oe", 0, charge_fet_drive_oe);
      chk("dis", 0, discharge_fet_drive);
      chk("irq masked", 0, irq);
      apb(1, 12'h00c, 1);
      cyc(2);
      chk("irq", 1, irq);
      @(posedge clk) rail_open <= 0;
      apb(1, 12'h008, 1);
      cyc(2);
      chk("irq clear", 0, irq);
   endtask
   task t_sense_temp;
      @(posedge clk) sense_open <= 1;
      cyc(3);
      chk("sense dis", 0, discharge_fet_drive);
      chk("sense oe", 1, charge_fet_drive_oe);
      @(posedge clk) sense_open <= 0;
      rst(3);
      @(posedge clk) {thermistor_sense, thermistor_release} <= 2'h3;
      cyc(100);
      @(posedge clk) {thermistor_sense, thermistor_release} <= 2'h0;
      cyc(2);
      chk("short hot", 1, charge_fet_drive_oe);
      @(posedge clk) {thermistor_sense, thermistor_release} <= 2'h3;
      wt(1, 0, 400);
      chk("detect time", 1, n >= 15 * TK);
      chk("hot dis", 0, discharge_fet_drive);
      @(posedge clk) thermistor_sense <= 0;
      cyc(200);
      chk("warm hold", 0, charge_fet_drive_oe);
      @(posedge clk) thermistor_release <= 0;
      wt(2, 1, 400);
      chk("release time", 1, n >= 15 * TK);
      chk("cool oe", 1, charge_fet_drive_oe);
      apb(0, 12'h008, 0);
      chk("irq status", 32'h18, rd);
   endtask
   task t_probe;
      wt(0, 1, PER + WIN);
      chk("odd first", 1, odd_group_switch);
      wt(0, 0, 2 * WIN);
      chk("window", 1, n >= WIN - 2 * TK && n <= WIN + 2 * TK);
      wt(0, 1, PER);
      chk("period", 1, n + WIN >= PER - 3 * TK && n + WIN <= PER + 3 * TK);
      chk("even next", 1, even_group_switch);
      @(posedge clk) {over_charge_cmp, over_discharge_cmp} <= 2'b11;
      repeat (20) @(posedge clk) tap_glitch <= ~tap_glitch;
      cyc(1);
      chk("oc held", 0, oc_delay_run);
      chk("od held", 0, od_delay_run);
      wt(0, 0, 2 * WIN);
      wt(3, 1, 40);
      chk("od after", 1, od_delay_run);
      chk("glitch oe", 1, charge_fet_drive_oe);
      rst(3);
      @(posedge clk) tap_broken <= 1;
      wt(1, 0, PER + 2 * WIN);
      chk("tap dis", 0, discharge_fet_drive);
      apb(0, 12'h004, 0);
      chk("status", 32'h24, rd);
      apb(0, 12'h008, 0);
      chk("irq tap", 32'h04, rd);
   endtask
   task t_modes;
      rst(0);
      wt(1, 1, 4);
      n = 0;
      repeat (PER + 2 * WIN) @(negedge clk) n += (mon[0] !== 1'b0);
      chk("no probe", 0, n);
      rst(3);
      apb(1, 12'h000, 0);
      n = 0;
      repeat (PER + 2 * WIN) @(negedge clk) n += (mon[0] !== 1'b0);
      chk("tap disabled", 0, n);
      apb(1, 12'h000, 3);
      cyc(2);
      chk("supply", 0, thermistor_supply);
      @(posedge clk) {thermistor_sense, thermistor_release} <= 2'h3;
      n = 0;
      repeat (PER + 2 * WIN) @(negedge clk) n += (mon[0] !== 1'b0);
      chk("standby probe", 0, n);
      chk("standby temp", 1, charge_fet_drive_oe);
      @(posedge clk) rail_open <= 1;
      cyc(3);
      chk("standby rail", 0, discharge_fet_drive);
   endtask
   initial
   begin
      {resetn, psel, penable, pwrite, paddr, pwdata, thermistor_release} = 0;
      {mode_select_a, mode_select_b, rail_open, sense_open, thermistor_sense} = 0;
      {over_charge_cmp, over_discharge_cmp, tap_broken, tap_glitch} = 0;
      rst(3);
      t_regs_rail();
      rst(3);
      t_sense_temp();
      rst(3);
      t_probe();
      t_modes();
      tally_and_finish();
   end
endmodule // testbench
